// ==== rtl/sync_err_consts.svh ====
// Offsets, field positions and reset values of the read error capture block
// Operation
// - Write-lost bit 20 keeps hard interrupt asserted
// - Cache parity error captures quadword virtual address
// - Lock bit qualifies parity flags, freezes address
// - Separate flags for data and tag parity
// - Uncorrectable fill latches address and syndrome
// - Fill errors caught from every data source
// - Held fill error kept; overflow bit 14
// - Held bus error kept; overflow bit 7
// - Error acknowledge or tag parity sets hard flag
// - Instruction error checks on dispatch or operand
// - Data error checks on use or tagged return
// - Ownership error checks on use; I/O inconsistent
// - Branch before use gives soft error interrupt
// - Fetch error machine checks report valid restart
// - Page entry write error traps, restart invalid
// - Lost fill behind uncorrectable keeps hard pending
`ifndef SYNC_ERR_CONSTS_SVH
`define SYNC_ERR_CONSTS_SVH

// Word indices; byte address is four times the index
`define IDX_BUS_STAT   4'h0
`define IDX_FILL_ADDR  4'h1
`define IDX_FILL_SYN   4'h2
`define IDX_IC_CTL     4'h3
`define IDX_IC_ADDR    4'h4
`define IDX_IRQ_STAT   4'h5
`define IDX_IRQ_CLR    4'h6
`define IDX_IRQ_EN     4'h7

// Bus unit error status fields
`define ST_HERR        0
`define ST_TAG_PARITY_ERROR_FLAG       1
`define ST_TAG_CONTROL_PARITY_ERROR_FLAG      2
`define ST_FILL_ECC    3
`define ST_FILL_CORR   4
`define ST_INCONS      5
`define ST_BUS_SEO     7
`define ST_FILL_SECOND_ERROR_OVERFLOW    14
`define ST_WRITE_LOST  20
`define ST_W1C_MASK    32'h0010_40bf

// Cache control status fields
`define IC_LOCK        0
`define IC_ICACHE_DATA_PARITY_FLAG       1
`define IC_TAG_PARITY_ERROR_FLAG       2

// Interrupt status fields
`define IRQ_MCHK       0
`define IRQ_SOFT       1
`define IRQ_HARD       2
`define IRQ_W          3

`define QW_MASK        32'hffff_fff8
`define RST_WORD       32'h0000_0000
`define RST_SYN        8'h00
`define RST_IRQ        3'h0

`endif

// ==== rtl/sync_err_pkg.sv ====
// Types for the read error capture block
package sync_err_pkg;
   typedef enum logic [1:0] {SRC_BCACHE = 2'h0, SRC_OTHER_CPU = 2'h1,
                             SRC_MEMORY = 2'h3, SRC_SYSBUS = 2'h2} fill_src_e;
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} bus_st_e;
   typedef struct packed {
      logic        err;
      logic        correctable;
      logic        istream;
      logic        own;
      fill_src_e   src;
      logic [31:0] addr;
      logic [7:0]  syn;
   } fill_evt_s;
   typedef struct packed {
      logic done;
      logic cack;
      logic tag_parity_error_flag;
      logic tag_control_parity_error_flag;
      logic istream;
      logic own;
      logic io;
      logic write_lost;
   } bus_evt_s;
   typedef struct packed {
      logic        data_par;
      logic        tag_par;
      logic [31:0] vaddr;
   } ic_evt_s;
   typedef struct packed {
      logic dispatch;
      logic istream_operand;
      logic prefetch_use;
      logic err_return;
      logic branch_exc;
      logic pte_wr_trap;
   } ebox_evt_s;
endpackage : sync_err_pkg

// ==== rtl/sync_read_error_capture.sv ====
// Capture, overflow and delivery of synchronous read errors
`timescale 1ns/1ps
`include "sync_err_consts.svh"
module sync_read_error_capture (
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   input  wire logic [5:0]             address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [31:0]            writedata,
   output logic [31:0]                 readdata,
   output logic                        waitrequest,
   input  wire sync_err_pkg::fill_evt_s fill,
   input  wire sync_err_pkg::bus_evt_s  bus,
   input  wire sync_err_pkg::ic_evt_s   ic,
   input  wire sync_err_pkg::ebox_evt_s ev,
   output logic                        machine_check,
   output logic                        valid_restart_indication,
   output logic                        soft_error_int,
   output logic                        hard_error_int,
   output logic                        irq
);
   sync_err_pkg::bus_st_e  st_r, st_nxt;
   logic                   wait_r, wait_nxt;
   logic [31:0]            rdata_r, rdata_nxt;
   logic [31:0]            bus_unit_error_status_r, stat_nxt;
   logic [31:0]            fill_addr_r, fill_addr_nxt;
   logic [7:0]             fill_syn_r, fill_syn_nxt;
   logic [2:0]             icache_control_status_r, icache_control_status_nxt;
   logic [31:0]            icache_error_address_r, icaddr_nxt;
   logic [`IRQ_W-1:0]      irq_stat_r, irq_stat_nxt;
   logic [`IRQ_W-1:0]      irq_en_r, irq_en_nxt;
   logic                   pend_i_r, pend_i_nxt;
   logic                   pend_d_r, pend_d_nxt;
   logic                   pend_o_r, pend_o_nxt;
   logic                   mchk_r, mchk_nxt;
   logic                   vr_r, vr_nxt;
   logic                   soft_r, hard_r, irq_r;
   logic                   hard_nxt;
   logic                   wr_go;
   logic [3:0]             idx;
   logic [31:0]            st_clr;
   logic                   ic_unlock;
   logic [`IRQ_W-1:0]      irq_clr;
   logic                   fill_free, bus_free, bus_err, abandon;
   logic                   take_i, take_d, take_o;

   assign idx = address[5:2];
   // Writes land only at the edge where waitrequest is seen low
   assign wr_go     = write && (st_r == sync_err_pkg::BUS_ACK);
   assign st_clr    = (wr_go && idx == `IDX_BUS_STAT) ? (writedata & `ST_W1C_MASK) : `RST_WORD;
   assign ic_unlock = wr_go && idx == `IDX_IC_CTL && writedata[`IC_LOCK];
   assign irq_clr   = (wr_go && idx == `IDX_IRQ_CLR) ? writedata[`IRQ_W-1:0] : `RST_IRQ;

   // Register slave: one wait cycle, then the answer
   always_comb begin
      st_nxt    = st_r;
      wait_nxt  = 1'b1;
      rdata_nxt = rdata_r;
      case (st_r)
         sync_err_pkg::BUS_IDLE: begin
            if (read || write) begin
               st_nxt   = sync_err_pkg::BUS_ACK;
               wait_nxt = 1'b0;
               case (idx)
                  `IDX_BUS_STAT:  rdata_nxt = bus_unit_error_status_r;
                  `IDX_FILL_ADDR: rdata_nxt = fill_addr_r;
                  `IDX_FILL_SYN:  rdata_nxt = {24'h00_0000, fill_syn_r};
                  `IDX_IC_CTL:    rdata_nxt = {29'h0000_0000, icache_control_status_r};
                  `IDX_IC_ADDR:   rdata_nxt = icache_error_address_r;
                  `IDX_IRQ_STAT:  rdata_nxt = {29'h0000_0000, irq_stat_r};
                  `IDX_IRQ_EN:    rdata_nxt = {29'h0000_0000, irq_en_r};
                  default:        rdata_nxt = `RST_WORD; // Unmapped and write-only
               endcase
            end
         end
         sync_err_pkg::BUS_ACK: begin
            st_nxt = sync_err_pkg::BUS_IDLE;
         end
         default: begin
            st_nxt = sync_err_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_r    <= sync_err_pkg::BUS_IDLE;
         wait_r  <= 1'b1;
         rdata_r <= `RST_WORD;
      end else begin
         st_r    <= st_nxt;
         wait_r  <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Error capture; every set is applied after the clear so it wins
   always_comb begin
      stat_nxt      = bus_unit_error_status_r & ~st_clr;
      fill_addr_nxt = fill_addr_r;
      fill_syn_nxt  = fill_syn_r;
      icache_control_status_nxt      = icache_control_status_r;
      icaddr_nxt    = icache_error_address_r;
      pend_i_nxt    = pend_i_r;
      pend_d_nxt    = pend_d_r;
      pend_o_nxt    = pend_o_r;
      // A logged entry freed this very cycle may take the new error
      fill_free = !bus_unit_error_status_r[`ST_FILL_ECC] || st_clr[`ST_FILL_ECC];
      bus_free  = !bus_unit_error_status_r[`ST_HERR] || st_clr[`ST_HERR];
      bus_err   = bus.done && (bus.cack || bus.tag_parity_error_flag || bus.tag_control_parity_error_flag);
      take_i    = pend_i_r && (ev.dispatch || ev.istream_operand);
      take_d    = pend_d_r && (ev.prefetch_use || ev.err_return);
      take_o    = pend_o_r && ev.prefetch_use;
      // Page entry write errors trap at any point in a flow
      mchk_nxt  = take_i || take_d || take_o || ev.pte_wr_trap;
      vr_nxt    = mchk_nxt ? !ev.pte_wr_trap : vr_r;
      abandon   = ev.branch_exc && !mchk_nxt && (pend_i_r || pend_d_r || pend_o_r);
      if (mchk_nxt || abandon) begin
         pend_i_nxt = 1'b0;
         pend_d_nxt = 1'b0;
         pend_o_nxt = 1'b0;
      end
      if (bus.write_lost) begin
         stat_nxt[`ST_WRITE_LOST] = 1'b1;
      end
      // Source does not matter: cache, other cpu, memory or system bus
      if (fill.err) begin
         if (fill_free) begin
            stat_nxt[`ST_FILL_ECC]  = 1'b1;
            stat_nxt[`ST_FILL_CORR] = fill.correctable;
            fill_addr_nxt = fill.addr;
            fill_syn_nxt  = fill.syn;
            if (!fill.correctable) begin
               pend_i_nxt = pend_i_nxt || fill.istream;
               pend_d_nxt = pend_d_nxt || (!fill.istream && !fill.own);
               pend_o_nxt = pend_o_nxt || (!fill.istream && fill.own);
            end
         end else begin
            stat_nxt[`ST_FILL_SECOND_ERROR_OVERFLOW] = 1'b1;
         end
      end
      if (bus_err) begin
         if (bus_free) begin
            stat_nxt[`ST_HERR]   = 1'b1;
            stat_nxt[`ST_TAG_PARITY_ERROR_FLAG]  = bus.tag_parity_error_flag;
            stat_nxt[`ST_TAG_CONTROL_PARITY_ERROR_FLAG] = bus.tag_control_parity_error_flag;
            if (bus.own && bus.io) begin
               stat_nxt[`ST_INCONS] = 1'b1;
            end
            pend_i_nxt = pend_i_nxt || bus.istream;
            pend_d_nxt = pend_d_nxt || (!bus.istream && !bus.own);
            pend_o_nxt = pend_o_nxt || (!bus.istream && bus.own);
         end else begin
            stat_nxt[`ST_BUS_SEO] = 1'b1;
         end
      end
      // Unlock also drops the flags, so a clear lock means no error
      if (ic_unlock) begin
         icache_control_status_nxt = 3'h0;
      end
      if ((ic.data_par || ic.tag_par) && !icache_control_status_nxt[`IC_LOCK]) begin
         icache_control_status_nxt[`IC_LOCK]  = 1'b1;
         icache_control_status_nxt[`IC_ICACHE_DATA_PARITY_FLAG] = ic.data_par;
         icache_control_status_nxt[`IC_TAG_PARITY_ERROR_FLAG] = ic.tag_par;
         icaddr_nxt = ic.vaddr & `QW_MASK;
         pend_i_nxt = 1'b1;
      end
      // Lost errors behind an uncorrectable entry mean data is gone
      hard_nxt = stat_nxt[`ST_WRITE_LOST] || stat_nxt[`ST_BUS_SEO]
                 || (stat_nxt[`ST_FILL_SECOND_ERROR_OVERFLOW] && !stat_nxt[`ST_FILL_CORR]);
      irq_en_nxt = (wr_go && idx == `IDX_IRQ_EN) ? writedata[`IRQ_W-1:0] : irq_en_r;
      irq_stat_nxt = irq_stat_r & ~irq_clr;
      irq_stat_nxt[`IRQ_MCHK] = irq_stat_nxt[`IRQ_MCHK] || mchk_nxt;
      irq_stat_nxt[`IRQ_SOFT] = irq_stat_nxt[`IRQ_SOFT] || abandon;
      irq_stat_nxt[`IRQ_HARD] = irq_stat_nxt[`IRQ_HARD] || hard_nxt;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bus_unit_error_status_r <= `RST_WORD;
         fill_addr_r             <= `RST_WORD;
         fill_syn_r              <= `RST_SYN;
         icache_control_status_r <= 3'h0;
         icache_error_address_r  <= `RST_WORD;
         irq_stat_r              <= `RST_IRQ;
         irq_en_r                <= `RST_IRQ;
         pend_i_r                <= 1'b0;
         pend_d_r                <= 1'b0;
         pend_o_r                <= 1'b0;
         mchk_r                  <= 1'b0;
         vr_r                    <= 1'b0;
         soft_r                  <= 1'b0;
         hard_r                  <= 1'b0;
         irq_r                   <= 1'b0;
      end else begin
         bus_unit_error_status_r <= stat_nxt;
         fill_addr_r             <= fill_addr_nxt;
         fill_syn_r              <= fill_syn_nxt;
         icache_control_status_r <= icache_control_status_nxt;
         icache_error_address_r  <= icaddr_nxt;
         irq_stat_r              <= irq_stat_nxt;
         irq_en_r                <= irq_en_nxt;
         pend_i_r                <= pend_i_nxt;
         pend_d_r                <= pend_d_nxt;
         pend_o_r                <= pend_o_nxt;
         mchk_r                  <= mchk_nxt;
         vr_r                    <= vr_nxt;
         soft_r                  <= irq_stat_nxt[`IRQ_SOFT];
         hard_r                  <= hard_nxt;
         irq_r                   <= |(irq_stat_nxt & irq_en_nxt);
      end
   end

   // Outputs straight from flops
   assign readdata                 = rdata_r;
   assign waitrequest              = wait_r;
   assign machine_check            = mchk_r;
   assign valid_restart_indication = vr_r;
   assign soft_error_int           = soft_r;
   assign hard_error_int           = hard_r;
   assign irq                      = irq_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   // Register slave answers one cycle after taking a request
   idle_answer_a: assert property (
      (read || write) && st_r == sync_err_pkg::BUS_IDLE |=> !waitrequest)
      else $error("request not answered in one cycle");

   wait_pulse_a: assert property (
      !waitrequest |=> waitrequest)
      else $error("waitrequest low for two cycles");

   // Interrupt line follows enabled status bits
   irq_match_a: assert property (
      irq == |(irq_stat_r & irq_en_r))
      else $error("interrupt line disagrees with status");

   // Steps of an instruction-stream error: logged, then dispatched
   sequence s_ierr_logged;
      bus.done && bus.cack && bus.istream && bus_free && !mchk_nxt && !abandon;
   endsequence
   sequence s_dispatch;
      ev.dispatch && !ev.pte_wr_trap;
   endsequence

   // Lost errors and the hard interrupt
   write_lost_hard_a: assert property (
      bus_unit_error_status_r[`ST_WRITE_LOST] |-> hard_error_int)
      else $error("write lost set without hard interrupt");

   write_lost_set_a: assert property (
      bus.write_lost |=> bus_unit_error_status_r[`ST_WRITE_LOST])
      else $error("lost write not recorded");

   ic_addr_align_a: assert property (
      ((ic.data_par || ic.tag_par) && !icache_control_status_r[`IC_LOCK] && !ic_unlock)
      |=> icache_error_address_r == ($past(ic.vaddr) & `QW_MASK))
      else $error("cache error address not captured");

   ic_par_pend_a: assert property (
      (ic.data_par || ic.tag_par) && !icache_control_status_r[`IC_LOCK] |=> pend_i_r)
      else $error("cache parity error not pending");

   ic_addr_freeze_a: assert property (
      icache_control_status_r[`IC_LOCK] && !ic_unlock |=> $stable(icache_error_address_r))
      else $error("locked error address changed");

   ic_quiet_a: assert property (
      !icache_control_status_r[`IC_LOCK] && !ic.data_par && !ic.tag_par
      |=> !(|icache_control_status_r))
      else $error("parity flags set without a locked error");

   ic_flag_split_a: assert property (
      (ic.data_par && !ic.tag_par && !icache_control_status_r[`IC_LOCK])
      |=> icache_control_status_r[`IC_ICACHE_DATA_PARITY_FLAG] && !icache_control_status_r[`IC_TAG_PARITY_ERROR_FLAG])
      else $error("data parity flagged as tag parity");

   ic_tag_split_a: assert property (
      (ic.tag_par && !ic.data_par && !icache_control_status_r[`IC_LOCK])
      |=> icache_control_status_r[`IC_TAG_PARITY_ERROR_FLAG] && !icache_control_status_r[`IC_ICACHE_DATA_PARITY_FLAG])
      else $error("tag parity flagged as data parity");

   fill_capture_a: assert property (
      fill.err && fill_free |=> fill_addr_r == $past(fill.addr) && fill_syn_r == $past(fill.syn))
      else $error("fill address or syndrome not latched");

   // Fill errors from any source; a held entry is never overwritten
   fill_source_a: assert property (
      fill.err && fill_free |=> bus_unit_error_status_r[`ST_FILL_ECC])
      else $error("fill error not logged");

   fill_overflow_a: assert property (
      fill.err && !fill_free |=> bus_unit_error_status_r[`ST_FILL_SECOND_ERROR_OVERFLOW] && $stable(fill_addr_r))
      else $error("held fill error overwritten");

   fill_syn_hold_a: assert property (
      fill.err && !fill_free |=> $stable(fill_syn_r))
      else $error("held fill syndrome overwritten");

   bus_overflow_a: assert property (
      bus_err && !bus_free |=> bus_unit_error_status_r[`ST_BUS_SEO])
      else $error("bus overflow flag not set");

   // Bus errors; the held entry stays put
   bus_hold_a: assert property (
      bus_err && !bus_free |=> bus_unit_error_status_r[`ST_HERR])
      else $error("held bus error dropped");

   tag_herr_a: assert property (
      bus.done && bus.tag_parity_error_flag && bus_free
      |=> bus_unit_error_status_r[`ST_HERR] && bus_unit_error_status_r[`ST_TAG_PARITY_ERROR_FLAG])
      else $error("tag parity did not set hard flag");

   tag_control_parity_error_flag_flag_a: assert property (
      bus.done && bus.tag_control_parity_error_flag && bus_free
      |=> bus_unit_error_status_r[`ST_HERR] && bus_unit_error_status_r[`ST_TAG_CONTROL_PARITY_ERROR_FLAG])
      else $error("tag control parity did not set hard flag");

   ierr_mchk_a: assert property (
      s_ierr_logged ##1 s_dispatch |=> machine_check ##1 !machine_check)
      else $error("instruction error dispatch gave no machine check");

   // Delivery only on consuming events
   operand_mchk_a: assert property (
      pend_i_r && ev.istream_operand |=> machine_check)
      else $error("operand access gave no machine check");

   quiet_mchk_a: assert property (
      !ev.dispatch && !ev.istream_operand && !ev.prefetch_use && !ev.err_return
      && !ev.pte_wr_trap |=> !machine_check)
      else $error("machine check without consuming event");

   data_mchk_a: assert property (
      pend_d_r && ev.err_return |=> machine_check)
      else $error("tagged data return gave no machine check");

   prefetch_mchk_a: assert property (
      pend_d_r && ev.prefetch_use |=> machine_check)
      else $error("prefetched data use gave no machine check");

   own_mchk_a: assert property (
      machine_check && !$past(ev.pte_wr_trap) |-> $past(pend_i_r || pend_d_r || pend_o_r))
      else $error("machine check without pending error");

   // Inconsistent report for ownership reads to I/O
   io_incons_a: assert property (
      bus_err && bus_free && bus.own && bus.io |=> bus_unit_error_status_r[`ST_INCONS])
      else $error("ownership error to I/O not inconsistent");

   soft_deliver_a: assert property (
      abandon |=> soft_error_int && !machine_check)
      else $error("abandoned error not soft interrupt");

   soft_cause_a: assert property (
      $rose(soft_error_int) |-> $past(abandon))
      else $error("soft interrupt without abandoned error");

   restart_a: assert property (
      machine_check && !$past(ev.pte_wr_trap) |-> valid_restart_indication)
      else $error("valid restart missing");

   pte_trap_a: assert property (
      ev.pte_wr_trap |=> machine_check && !valid_restart_indication)
      else $error("page entry trap mishandled");

   lost_fill_hard_a: assert property (
      bus_unit_error_status_r[`ST_FILL_SECOND_ERROR_OVERFLOW] && !bus_unit_error_status_r[`ST_FILL_CORR]
      |-> hard_error_int)
      else $error("lost fill without hard interrupt");

   // A correctable logged fill keeps lost fills soft
   lost_fill_soft_a: assert property (
      bus_unit_error_status_r[`ST_FILL_SECOND_ERROR_OVERFLOW] && bus_unit_error_status_r[`ST_FILL_CORR]
      && !bus_unit_error_status_r[`ST_WRITE_LOST] && !bus_unit_error_status_r[`ST_BUS_SEO]
      |-> !hard_error_int)
      else $error("lost correctable fill raised hard interrupt");

   herr_hold_a: assert property (
      bus_unit_error_status_r[`ST_HERR] && !st_clr[`ST_HERR]
      |=> bus_unit_error_status_r[`ST_HERR])
      else $error("hard flag dropped without clear");

   // Captured values move only on a logged event
   capture_hold_a: assert property (
      !fill.err |=> $stable(fill_addr_r) && $stable(fill_syn_r))
      else $error("fill capture changed without an error");
endmodule : sync_read_error_capture

// ==== tb/sync_read_error_capture_tb.sv ====
// Self-checking bench for the read error capture block
`timescale 1ns/1ps
`include "sync_err_consts.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %0t value mismatch got %h exp %h", $time, got, exp); end end
module sync_read_error_capture_tb;
   logic                     ref_clk;
   logic                     rstn;
   logic [5:0]               address;
   logic                     read;
   logic                     write;
   logic [31:0]              writedata;
   logic [31:0]              readdata;
   logic                     waitrequest;
   sync_err_pkg::fill_evt_s  fill;
   sync_err_pkg::bus_evt_s   bus;
   sync_err_pkg::ic_evt_s    ic;
   sync_err_pkg::ebox_evt_s  ev;
   logic                     machine_check;
   logic                     valid_restart_indication;
   logic                     soft_error_int;
   logic                     hard_error_int;
   logic                     irq;
   int                       mismatches = 0;
   int                       n_tests = 0;
   int                       cyc = 0;
   logic [31:0]              rd, a0, a1;
   logic [7:0]               s0;

   sync_read_error_capture u_sync_read_error_capture (
      .ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .fill(fill), .bus(bus), .ic(ic), .ev(ev), .machine_check(machine_check),
      .valid_restart_indication(valid_restart_indication),
      .soft_error_int(soft_error_int), .hard_error_int(hard_error_int), .irq(irq));

   // 25 ns clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // Avalon cycle: request held until waitrequest is sampled low
   task automatic bus_xfer(input logic [3:0] idx, input logic wr, input logic [31:0] wd,
                           output logic [31:0] q);
      @(posedge ref_clk);
      address   <= {idx, 2'b00};
      read      <= ~wr;
      write     <= wr;
      writedata <= wd;
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus_xfer

   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      bus_xfer(idx, 1'b0, 32'h0, rd);
      `CHK(rd, exp)
   endtask : rd_chk

   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      bus_xfer(idx, 1'b1, d, rd);
   endtask : wr

   // Bus event, then execution event a cycle later; outputs read once settled
   task automatic pulse(input logic [7:0] b, input logic [5:0] e);
      @(posedge ref_clk);
      bus <= sync_err_pkg::bus_evt_s'(b);
      @(posedge ref_clk);
      bus <= '0;
      ev  <= sync_err_pkg::ebox_evt_s'(e);
      @(posedge ref_clk);
      ev  <= '0;
      #1;
   endtask : pulse

   task automatic fill_err(input logic corr, input logic ist, input logic [1:0] src,
                           input logic [31:0] a, input logic [7:0] s);
      @(posedge ref_clk);
      fill <= '{err: 1'b1, correctable: corr, istream: ist, own: 1'b0,
                src: sync_err_pkg::fill_src_e'(src), addr: a, syn: s};
      @(posedge ref_clk);
      fill <= '0;
   endtask : fill_err

   // Status first, so the hard interrupt bit cannot re-set behind the clear
   task automatic clr();
      wr(4'h0, 32'hffff_ffff);
      wr(4'h3, 32'h0000_0001);
      wr(4'h6, 32'h0000_0007);
      #1;
   endtask : clr

   function automatic logic [31:0] bus_exp(input int k);
      return 32'h1 | (k == 1 ? 32'h2 : 32'h0) | (k == 2 ? 32'h4 : 32'h0);
   endfunction : bus_exp

   function automatic logic exp_hard(input logic wl, input logic bseo, input logic fseo,
                                     input logic fcorr);
      return wl | bseo | (fseo & ~fcorr);
   endfunction : exp_hard

   initial begin
      rstn = 1'b0; address = '0; read = 1'b0; write = 1'b0; writedata = '0;
      fill = '0; bus = '0; ic = '0; ev = '0;
      void'($urandom(32'hc92f));
      repeat (6) @(posedge ref_clk);
      `CHK(waitrequest, 1'b1)
      `CHK({machine_check, soft_error_int, hard_error_int, irq}, 4'h0)
      rstn <= 1'b1;
      // Every register reads zero after reset; index 8 is unmapped
      for (int i = 0; i < 9; i++) rd_chk(i[3:0], 32'h0);
      $display("test reset done");

      // Acknowledge error and both tag parity kinds, then a dispatch check
      for (int k = 0; k < 3; k++) begin
         clr();
         pulse({1'b1, k == 0, k == 1, k == 2, 1'b1, 3'h0}, 6'h20);
         `CHK({machine_check, valid_restart_indication}, 2'b11)
         #25;
         `CHK(machine_check, 1'b0)
         rd_chk(4'h0, bus_exp(k));
      end
      // Later error while the first is held only raises the overflow bit
      pulse(8'hd0, 6'h0);
      rd_chk(4'h0, 32'h85);
      #25;
      `CHK(hard_error_int, exp_hard(1'b0, 1'b1, 1'b0, 1'b0))
      $display("test bus errors done");

      // Ownership read to I/O, abandoned by a branch: soft interrupt, no check
      clr();
      `CHK(hard_error_int, 1'b0)
      pulse(8'hc6, 6'h0);
      rd_chk(4'h0, 32'h21);
      pulse(8'h0, 6'h02);
      `CHK(machine_check, 1'b0)
      #25;
      `CHK(soft_error_int, 1'b1)
      clr();
      `CHK(soft_error_int, 1'b0)
      pulse(8'hc4, 6'h0);
      pulse(8'h0, 6'h08);
      `CHK(machine_check, 1'b1)
      $display("test ownership done");

      // Uncorrectable fills from every source, then a lost second fill
      for (int s = 0; s < 4; s++) begin
         clr();
         a0 = $urandom;
         s0 = 8'($urandom);
         fill_err(1'b0, s == 1, s[1:0], a0, s0);
         rd_chk(4'h1, a0);
         rd_chk(4'h2, {24'h0, s0});
         rd_chk(4'h0, 32'h8);
         pulse(8'h0, (s == 1) ? 6'h20 : (s == 3) ? 6'h04 : 6'h08);
         `CHK({machine_check, valid_restart_indication}, 2'b11)
      end
      fill_err(1'b0, 1'b0, 2'h3, ~a0, ~s0);
      rd_chk(4'h1, a0);
      rd_chk(4'h0, 32'h4008);
      `CHK(hard_error_int, exp_hard(1'b0, 1'b0, 1'b1, 1'b0))
      // Lost fill behind a correctable entry stays soft
      clr();
      fill_err(1'b1, 1'b0, 2'h0, a0, s0);
      fill_err(1'b0, 1'b0, 2'h1, ~a0, ~s0);
      rd_chk(4'h0, 32'h4018);
      `CHK(hard_error_int, exp_hard(1'b0, 1'b0, 1'b1, 1'b1))
      $display("test fill done");

      // Page entry write trap: machine check without valid restart
      clr();
      pulse(8'h0, 6'h01);
      `CHK({machine_check, valid_restart_indication}, 2'b10)
      $display("test trap done");

      // Cache parity: lock freezes flags and address until cleared
      clr();
      a0 = $urandom;
      a1 = $urandom;
      @(posedge ref_clk);
      ic <= '{data_par: 1'b1, tag_par: 1'b0, vaddr: a0};
      @(posedge ref_clk);
      ic <= '{data_par: 1'b0, tag_par: 1'b1, vaddr: a1};
      @(posedge ref_clk);
      ic <= '0;
      rd_chk(4'h3, 32'h3);
      rd_chk(4'h4, a0 & `QW_MASK);
      wr(4'h3, 32'h1);
      rd_chk(4'h3, 32'h0);
      @(posedge ref_clk);
      ic <= '{data_par: 1'b0, tag_par: 1'b1, vaddr: a1};
      @(posedge ref_clk);
      ic <= '0;
      rd_chk(4'h3, 32'h5);
      rd_chk(4'h4, a1 & `QW_MASK);
      $display("test cache parity done");

      // Lost write keeps the hard interrupt up; enable, mask and clear
      clr();
      wr(4'h7, 32'h7);
      rd_chk(4'h7, 32'h7);
      pulse(8'h01, 6'h0);
      rd_chk(4'h0, 32'h0010_0000);
      `CHK(hard_error_int, 1'b1)
      rd_chk(4'h5, 32'h4);
      `CHK(irq, 1'b1)
      wr(4'h7, 32'h0);
      rd_chk(4'h6, 32'h0);
      `CHK(irq, 1'b0)
      clr();
      `CHK(hard_error_int, 1'b0)
      rd_chk(4'h5, 32'h0);
      $display("test interrupts done");
      end_of_test();
   end
endmodule : sync_read_error_capture_tb
